/* design/uerr_defines.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * for the USB error flag block. Assumes a 32-bit byte-addressed bus.
 */
`ifndef UERR_DEFINES_SVH
`define UERR_DEFINES_SVH

`define UERR_ADDR_W 4
`define UERR_OFS_FLAGS 4'h0
`define UERR_OFS_MASK 4'h4
`define UERR_OFS_CTRL 4'h8
`define UERR_OFS_STAT 4'hC

`define UERR_BIT_STUFF 7
`define UERR_BIT_DESC 6
`define UERR_BIT_DMA 5
`define UERR_BIT_TURN 4
`define UERR_BIT_PART 3
`define UERR_BIT_CRC16 2
`define UERR_BIT_CRC5 1
`define UERR_BIT_PID 0

`define UERR_FLAGS_RESET 8'h00
`define UERR_MASK_RESET 8'h00
`define UERR_CTRL_RESET 1'b0

`define UERR_TURN_BIT_TIMES 16
`define UERR_BIT_TIME_NS 83
`define UERR_CLK_NS 100
`define UERR_TURN_CYCLES ((`UERR_TURN_BIT_TIMES * `UERR_BIT_TIME_NS + `UERR_CLK_NS - 1) / `UERR_CLK_NS)
`define UERR_TURN_CNT_W 5

`endif

/* design/uerr_pkg.sv */
/*
 * Types for the USB error flag block.
 * Assumes uerr_defines.svh is available on the include path.
 */
package uerr_pkg;
    typedef enum logic [1:0] {
        UERR_BUS_IDLE = 2'b00,
        UERR_BUS_ACK = 2'b01
    } uerr_bus_t;
endpackage

/* design/uerr_turn_timer.sv */
/*
 * Bus turnaround timer: counts idle cycles after an end of packet.
 * Assumes arm, response and idle are same-clock pulses/levels.
 */
`timescale 1ns/10ps
`include "uerr_defines.svh"
module uerr_turn_timer
    import uerr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic eop_seen,
    input wire logic response_seen,
    input wire logic line_idle,
    output logic timeout
);
    logic [`UERR_TURN_CNT_W-1:0] count_q;
    logic armed_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            armed_q <= 1'b0;
            count_q <= '0;
        end else if (eop_seen) begin
            armed_q <= 1'b1;
            count_q <= '0;
        end else if (response_seen || !line_idle || timeout) begin
            armed_q <= 1'b0;
            count_q <= '0;
        end else if (armed_q) begin
            count_q <= count_q + `UERR_TURN_CNT_W'(1);
        end
    end

    // Fires once when idle passes sixteen bit times
    assign timeout = armed_q && line_idle && !response_seen &&
        (count_q >= `UERR_TURN_CNT_W'(`UERR_TURN_CYCLES));
endmodule

/* design/uerr_flags.sv */
/*
 * USB error status flags with Avalon-MM slave, mask and interrupt.
 * Assumes error event inputs are one-cycle pulses from logic on clock.
 */
`timescale 1ns/10ps
`include "uerr_defines.svh"
module uerr_flags
    import uerr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [`UERR_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic stuff_violation,
    input wire logic descriptor_base_bad,
    input wire logic buffer_address_bad,
    input wire logic dma_grant_late,
    input wire logic packet_truncated,
    input wire logic eop_seen,
    input wire logic response_seen,
    input wire logic line_idle,
    input wire logic data_field_partial,
    input wire logic data_crc_bad,
    input wire logic token_crc_bad,
    input wire logic sof_count_zero,
    input wire logic transfer_active,
    input wire logic pid_check_bad,
    output logic packet_reject,
    output logic any_error,
    output logic irq
);
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] mask_q;
    logic host_mode_q;
    logic [7:0] events;
    logic [7:0] clear_bits;
    logic turn_timeout;
    logic [31:0] rdata_q;
    uerr_bus_t bus_q;
    logic access;
    logic bus_take;

    uerr_turn_timer u_turn (
        .clock(clock),
        .reset(reset),
        .eop_seen(eop_seen),
        .response_seen(response_seen),
        .line_idle(line_idle),
        .timeout(turn_timeout)
    );

    always_comb begin
        events = 8'h00;
        events[`UERR_BIT_STUFF] = stuff_violation;
        events[`UERR_BIT_DESC] = descriptor_base_bad || buffer_address_bad;
        events[`UERR_BIT_DMA] = dma_grant_late || packet_truncated;
        events[`UERR_BIT_TURN] = turn_timeout;
        events[`UERR_BIT_PART] = data_field_partial;
        events[`UERR_BIT_CRC16] = data_crc_bad;
        // Bit 1 meaning follows the operating mode
        events[`UERR_BIT_CRC5] = host_mode_q ? (sof_count_zero && transfer_active)
                                             : token_crc_bad;
        events[`UERR_BIT_PID] = pid_check_bad;
    end

    // Rejection goes to the packet decoder in the same cycle
    assign packet_reject = stuff_violation || data_crc_bad || (!host_mode_q && token_crc_bad);

    // One-cycle wait state, then acknowledge
    assign access = avs_read || avs_write;
    assign bus_take = access && (bus_q == UERR_BUS_ACK);
    assign avs_waitrequest = access && (bus_q != UERR_BUS_ACK);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bus_q <= UERR_BUS_IDLE;
        end else begin
            case (bus_q)
                UERR_BUS_IDLE: bus_q <= access ? UERR_BUS_ACK : UERR_BUS_IDLE;
                UERR_BUS_ACK: bus_q <= UERR_BUS_IDLE;
                default: bus_q <= UERR_BUS_IDLE;
            endcase
        end
    end

    always_comb begin
        clear_bits = 8'h00;
        if (bus_take && avs_write && avs_byteenable[0] && avs_address == `UERR_OFS_FLAGS) begin
            clear_bits = avs_writedata[7:0];
        end
    end

    // Set wins over a clear in the same cycle
    assign flags_d = (flags_q & ~clear_bits) | events;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flags_q <= `UERR_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mask_q <= `UERR_MASK_RESET;
            host_mode_q <= `UERR_CTRL_RESET;
        end else if (bus_take && avs_write && avs_byteenable[0]) begin
            if (avs_address == `UERR_OFS_MASK) begin
                mask_q <= avs_writedata[7:0];
            end
            if (avs_address == `UERR_OFS_CTRL) begin
                host_mode_q <= avs_writedata[0];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (access && bus_q == UERR_BUS_IDLE && avs_read) begin
            case (avs_address)
                `UERR_OFS_FLAGS: rdata_q <= {24'h00_0000, flags_q};
                `UERR_OFS_MASK: rdata_q <= {24'h00_0000, mask_q};
                `UERR_OFS_CTRL: rdata_q <= {31'h0000_0000, host_mode_q};
                `UERR_OFS_STAT: rdata_q <= {30'h0000_0000, irq, any_error};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_q;

    assign any_error = |flags_q;
    assign irq = |(flags_q & mask_q);

    // Event to flag checks, one group per error source
    stuff_sets_a: assert property (@(posedge clock) disable iff (reset)
        stuff_violation |=> flags_q[`UERR_BIT_STUFF])
        else $error("stuff flag not set");
    stuff_rej_a: assert property (@(posedge clock) disable iff (reset)
        stuff_violation |-> packet_reject)
        else $error("stuff packet not rejected");
    desc_sets_a: assert property (@(posedge clock) disable iff (reset)
        (descriptor_base_bad || buffer_address_bad) |=> flags_q[`UERR_BIT_DESC])
        else $error("descriptor flag not set");
    dma_sets_a: assert property (@(posedge clock) disable iff (reset)
        (dma_grant_late || packet_truncated) |=> flags_q[`UERR_BIT_DMA])
        else $error("dma flag not set");
    turn_sets_a: assert property (@(posedge clock) disable iff (reset)
        (eop_seen ##1 (line_idle && !response_seen && !eop_seen)[*8] ##1
         (line_idle && !response_seen && !eop_seen)[*8] ##1
         (line_idle && !response_seen && !eop_seen))
        |-> ##[1:3] flags_q[`UERR_BIT_TURN])
        else $error("turnaround flag late");
    part_sets_a: assert property (@(posedge clock) disable iff (reset)
        data_field_partial |=> flags_q[`UERR_BIT_PART])
        else $error("partial byte flag not set");
    crc16_rej_a: assert property (@(posedge clock) disable iff (reset)
        data_crc_bad |-> packet_reject ##1 flags_q[`UERR_BIT_CRC16])
        else $error("crc16 not handled");
    crc5_dev_a: assert property (@(posedge clock) disable iff (reset)
        (!host_mode_q && token_crc_bad) |=> flags_q[`UERR_BIT_CRC5])
        else $error("crc5 flag not set");
    crc5_rej_a: assert property (@(posedge clock) disable iff (reset)
        (!host_mode_q && token_crc_bad) |-> packet_reject)
        else $error("bad token not rejected");
    crc5_quiet_a: assert property (@(posedge clock) disable iff (reset)
        (!host_mode_q && !token_crc_bad && !flags_q[`UERR_BIT_CRC5]) |=> !flags_q[`UERR_BIT_CRC5])
        else $error("bit 1 set without token error");
    eof_host_a: assert property (@(posedge clock) disable iff (reset)
        (host_mode_q && sof_count_zero && transfer_active) |=> flags_q[`UERR_BIT_CRC5])
        else $error("eof flag not set");
    eof_quiet_a: assert property (@(posedge clock) disable iff (reset)
        (host_mode_q && !(sof_count_zero && transfer_active) && !flags_q[`UERR_BIT_CRC5])
        |=> !flags_q[`UERR_BIT_CRC5])
        else $error("bit 1 set without frame end error");
    host_rej_a: assert property (@(posedge clock) disable iff (reset)
        (host_mode_q && !stuff_violation && !data_crc_bad) |-> !packet_reject)
        else $error("token rejected in host mode");
    pid_sets_a: assert property (@(posedge clock) disable iff (reset)
        pid_check_bad |=> flags_q[`UERR_BIT_PID])
        else $error("pid flag not set");
    flag_sticky_a: assert property (@(posedge clock) disable iff (reset)
        (flags_q[0] && !clear_bits[0]) |=> flags_q[0])
        else $error("flag dropped without clear");
    lane_off_a: assert property (@(posedge clock) disable iff (reset)
        (avs_write && !avs_byteenable[0] && events == 8'h00) |=> flags_q == $past(flags_q))
        else $error("flags changed by disabled lane");
    upper_zero_a: assert property (@(posedge clock) disable iff (reset)
        avs_readdata[31:8] == 24'h00_0000)
        else $error("upper bits not zero");
    read_flags_a: assert property (@(posedge clock) disable iff (reset)
        (avs_read && avs_waitrequest && avs_address == `UERR_OFS_FLAGS) |=> avs_readdata[7:0] == $past(flags_q))
        else $error("flag read data wrong");
    any_err_a: assert property (@(posedge clock) disable iff (reset)
        $rose(any_error) |-> $past(events) != 8'h00)
        else $error("error output without event");
    any_clear_a: assert property (@(posedge clock) disable iff (reset)
        $fell(any_error) |-> $past(clear_bits) != 8'h00)
        else $error("error output dropped without clear");

    for (genvar i = 0; i < 8; i++) begin : g_flag
        flag_clear_a: assert property (@(posedge clock) disable iff (reset)
            (clear_bits[i] && !events[i]) |=> !flags_q[i])
            else $error("flag not cleared by write of one");
        flag_win_a: assert property (@(posedge clock) disable iff (reset)
            (clear_bits[i] && events[i]) |=> flags_q[i])
            else $error("clear beat a new event");
        flag_quiet_a: assert property (@(posedge clock) disable iff (reset)
            (!flags_q[i] && !events[i]) |=> !flags_q[i])
            else $error("flag set without event");
    end

    // Register bus behaviour
    wait_first_a: assert property (@(posedge clock) disable iff (reset)
        (access && !$past(access)) |-> avs_waitrequest)
        else $error("no wait state on new request");
    wait_once_a: assert property (@(posedge clock) disable iff (reset)
        (access && avs_waitrequest) |=> (!access || !avs_waitrequest))
        else $error("more than one wait state");
    bus_ack_a: assert property (@(posedge clock) disable iff (reset)
        (bus_q == UERR_BUS_ACK) |=> (bus_q == UERR_BUS_IDLE))
        else $error("acknowledge state held");
    read_hold_a: assert property (@(posedge clock) disable iff (reset)
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved without read");
    status_read_a: assert property (@(posedge clock) disable iff (reset)
        (avs_read && avs_waitrequest && avs_address == `UERR_OFS_STAT)
        |=> avs_readdata[1:0] == {$past(irq), $past(any_error)})
        else $error("status read data wrong");
    mask_read_a: assert property (@(posedge clock) disable iff (reset)
        (avs_read && avs_waitrequest && avs_address == `UERR_OFS_MASK) |=> avs_readdata == {24'h00_0000, $past(mask_q)})
        else $error("mask read data wrong");
    ctrl_read_a: assert property (@(posedge clock) disable iff (reset)
        (avs_read && avs_waitrequest && avs_address == `UERR_OFS_CTRL)
        |=> avs_readdata == {31'h0000_0000, $past(host_mode_q)})
        else $error("control read data wrong");
    unmapped_rd_a: assert property (@(posedge clock) disable iff (reset)
        (avs_read && avs_waitrequest && avs_address[1:0] != 2'h0) |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    unmapped_wr_a: assert property (@(posedge clock) disable iff (reset)
        (avs_write && avs_address[1:0] != 2'h0) |=> ($stable(mask_q) && $stable(host_mode_q)))
        else $error("unmapped write changed a register");
    mask_write_a: assert property (@(posedge clock) disable iff (reset)
        (bus_take && avs_write && avs_byteenable[0] && avs_address == `UERR_OFS_MASK)
        |=> mask_q == 8'($past(avs_writedata)))
        else $error("mask write lost");
    mode_write_a: assert property (@(posedge clock) disable iff (reset)
        (bus_take && avs_write && avs_byteenable[0] && avs_address == `UERR_OFS_CTRL)
        |=> host_mode_q == 1'($past(avs_writedata)))
        else $error("mode write lost");

    // Wait cycles of the current request; the slave promises exactly one
    logic [1:0] wait_run_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wait_run_q <= 2'h0;
        end else if (access && avs_waitrequest) begin
            wait_run_q <= (wait_run_q == 2'h3) ? 2'h3 : wait_run_q + 2'h1;
        end else begin
            wait_run_q <= 2'h0;
        end
    end
    wait_bound_a: assert property (@(posedge clock) disable iff (reset)
        wait_run_q <= 2'h1)
        else $error("wait state count exceeded");

    // Idle run since the last end of packet, kept apart from the timer
    logic [`UERR_TURN_CNT_W-1:0] idle_run_q;
    logic idle_armed_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            idle_armed_q <= 1'b0;
            idle_run_q <= '0;
        end else if (eop_seen) begin
            idle_armed_q <= 1'b1;
            idle_run_q <= '0;
        end else if (response_seen || !line_idle) begin
            idle_armed_q <= 1'b0;
            idle_run_q <= '0;
        end else if (idle_armed_q && idle_run_q != '1) begin
            idle_run_q <= idle_run_q + `UERR_TURN_CNT_W'(1);
        end
    end
    turn_early_a: assert property (@(posedge clock) disable iff (reset)
        (idle_armed_q && idle_run_q < `UERR_TURN_CNT_W'(`UERR_TURN_CYCLES)) |-> !turn_timeout)
        else $error("turnaround timeout too early");
    turn_late_a: assert property (@(posedge clock) disable iff (reset)
        (idle_armed_q && line_idle && !response_seen && !eop_seen
         && idle_run_q == `UERR_TURN_CNT_W'(`UERR_TURN_CYCLES)) |=> flags_q[`UERR_BIT_TURN])
        else $error("turnaround flag missing");
endmodule

/* testbench/uerr_usb_partner.sv */
/*
 * USB partner model: raises one bus event of the requested kind.
 * Assumes the bench asks for one event at a time on clock.
 */
`timescale 1ns/10ps
module uerr_usb_partner (
    input wire logic clock,
    input wire logic reset,
    input wire logic fire,
    input wire logic [3:0] kind,
    output logic [11:0] ev
);
    // One-cycle pulses; level events last one cycle too
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ev <= 12'h000;
        end else begin
            ev <= fire ? (12'h001 << kind) : 12'h000;
        end
    end
endmodule

/* testbench/tb.sv */
/*
 * Bench for uerr_flags: event traffic from the partner, register checks.
 * Assumes the partner model drives every event input, with transfer_active also gated by busy.
 */
`timescale 1ns/10ps
`include "uerr_defines.svh"
module tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic fire = 1'b0;
    logic busy = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [3:0] kind = 4'h0;
    logic [3:0] be = 4'hF;
    logic [3:0] rk;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic [11:0] ev;
    logic waitreq, rej, anye, irq;
    logic [7:0] expf, mask;
    int err_total = 0;
    int n_checks = 0;
    int seed = 32'h216d;
    always #50 clock = ~clock;
    uerr_usb_partner i_uerr_usb_partner (.clock(clock), .reset(reset), .fire(fire), .kind(kind), .ev(ev));
    uerr_flags i_uerr_flags (.clock(clock), .reset(reset), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .stuff_violation(ev[9]), .descriptor_base_bad(ev[7]), .buffer_address_bad(ev[8]),
        .dma_grant_late(ev[5]), .packet_truncated(ev[6]), .eop_seen(ev[4]), .response_seen(ev[11]),
        .line_idle(~ev[11]), .data_field_partial(ev[3]), .data_crc_bad(ev[2]), .token_crc_bad(ev[1]),
        .sof_count_zero(ev[10]), .transfer_active(ev[10] && busy), .pid_check_bad(ev[0]),
        .packet_reject(rej), .any_error(anye), .irq(irq));
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Called just after a rising edge; holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clock);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) check("waitrequest", 32'h0, 32'h1);
        @(posedge clock);
    endtask
    task automatic raise(input logic [3:0] k, input logic exp_rej);
        kind <= k;
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        @(posedge clock);
        check("packet_reject", {31'h0, exp_rej}, {31'h0, rej});
        @(posedge clock);
    endtask
    function automatic logic [7:0] bit_of(input logic [3:0] k);
        case (k)
            4'h6: return 8'h20;
            4'h7, 4'h8: return 8'h40;
            4'h9: return 8'h80;
            4'hA: return 8'h02;
            default: return 8'h01 << k;
        endcase
    endfunction
    initial begin
        #2000000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        bus(0, `UERR_OFS_FLAGS, 32'h0, 4'hF);
        check("flags reset", 32'h0, rv);
        bus(0, `UERR_OFS_MASK, 32'h0, 4'hF);
        check("mask reset", 32'h0, rv);
        check("any_error reset", 32'h0, {31'h0, anye});
        for (int k = 0; k < 11; k++) begin
            if (k == 10) bus(1, `UERR_OFS_CTRL, 32'h1, 4'hF);
            raise(4'(k), k == 1 || k == 2 || k == 9);
            if (k == 4) repeat (16) @(posedge clock);
            bus(0, `UERR_OFS_FLAGS, 32'h0, 4'hF);
            check("flag set", {24'h0, bit_of(4'(k))}, rv);
            check("any_error", 32'h1, {31'h0, anye});
            bus(1, `UERR_OFS_FLAGS, {24'h0, ~bit_of(4'(k))}, 4'hF);
            bus(0, `UERR_OFS_FLAGS, 32'h0, 4'hF);
            check("flag kept", {24'h0, bit_of(4'(k))}, rv);
            bus(1, `UERR_OFS_FLAGS, {24'hFFFFFF, bit_of(4'(k))}, 4'hF);
            bus(0, `UERR_OFS_FLAGS, 32'h0, 4'hF);
            check("flag cleared", 32'h0, rv);
        end
        // Host mode: token checksum failures must not reach bit 1
        // Frame counter at zero with no traffic is no frame end error
        busy <= 1'b0;
        raise(4'hA, 1'b0);
        busy <= 1'b1;
        raise(4'h1, 1'b0);
        bus(1, `UERR_OFS_CTRL, 32'h0, 4'hF);
        raise(4'h4, 1'b0);
        raise(4'hB, 1'b0);
        repeat (20) @(posedge clock);
        bus(0, `UERR_OFS_FLAGS, 32'h0, 4'hF);
        check("no timeout", 32'h0, rv);
        mask = 8'($random(seed));
        bus(1, `UERR_OFS_MASK, {24'hFFFFFF, mask}, 4'hF);
        bus(0, `UERR_OFS_MASK, 32'h0, 4'hF);
        check("mask", {24'h0, mask}, rv);
        expf = 8'h00;
        repeat (6) begin
            rk = 4'($unsigned($random(seed)) % 9);
            if (rk > 3) rk++;
            raise(rk, rk == 1 || rk == 2 || rk == 9);
            expf |= bit_of(rk);
        end
        bus(0, `UERR_OFS_FLAGS, 32'h0, 4'hF);
        check("flags", {24'h0, expf}, rv);
        check("irq", {31'h0, |(expf & mask)}, {31'h0, irq});
        bus(0, `UERR_OFS_STAT, 32'h0, 4'hF);
        check("status", {30'h0, |(expf & mask), |expf}, rv);
        bus(1, `UERR_OFS_MASK, 32'h0, 4'hF);
        check("irq masked", 32'h0, {31'h0, irq});
        bus(1, 4'h2, 32'hFF, 4'hF);
        bus(0, 4'h2, 32'h0, 4'hF);
        check("unmapped", 32'h0, rv);
        bus(1, `UERR_OFS_FLAGS, 32'hFF, 4'h0);
        bus(0, `UERR_OFS_FLAGS, 32'h0, 4'hF);
        check("lane off", {24'h0, expf}, rv);
        bus(1, `UERR_OFS_FLAGS, 32'hFF, 4'h1);
        check("any_error cleared", 32'h0, {31'h0, anye});
        stop_test();
    end
endmodule
